// *** src/cfg_index_data.sv ***
// configuration index/data register access unit
//------------------------------------------------------------------------------
// How it works
// R1: strap at reset picks 2Eh/2Fh or 4Eh/4Fh
// R2: index pointer read/write, resets to 00h
// R3: data port forwards to pointed register
// R4: only index 30h reaches selected bank
// R5: index 07h selects one of 13 banks
// R6: banks 00h-0Ch map to fixed logical devices
// R7: unimplemented writes ignored, reads return 00h
// R8: unimplemented 74h/75h read back 04h
// R9: accessible after the third clock edge after reset ends
// R10: registers read/write, reserved bits read 0
// R11: host preserves reserved bits by read-modify-write
// R12: host writes write-only registers plainly
// R13: activation bit 0 at 30h, rest reserved
// R14: indices 20h-2Fh global, bank independent
// R15: 8-bit i/o read and write bridged
// R16: inactive device registers and resources unused
// R17: reserved bank value makes banked access unimplemented
//------------------------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module cfg_index_data (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    // strap pin
    input  wire logic                   port_address_strap,
    // internal i/o cycle from the host bridge
    input  wire cfg_pkg::cfg_io_s       io,
    output logic                        io_hit,
    output logic [7:0]                  io_rdata,
    // per-device activation to the functional blocks
    output logic [cfg_pkg::NUM_BANKS-1:0] device_enable
);
    // strap runs through both synchroniser stages before it is caught
    typedef enum logic [3:0] {
        ST_FILL   = 4'b0001,
        ST_SETTLE = 4'b0010,
        ST_CATCH  = 4'b0100,
        ST_RUN    = 4'b1000
    } cfg_state_e;

    typedef struct packed {
        cfg_state_e                           st;
        logic [1:0]                           strap_sync;
        logic                                 high_base;
        logic [7:0]                           config_pointer;
        logic [7:0]                           bank_number;
        logic [cfg_pkg::NUM_BANKS-1:0]        act;
        logic [cfg_pkg::NUM_GLOBAL-1:0][7:0]  global_reg;
        logic [7:0]                           rdata;
    } cfg_state_s;

    cfg_state_s r;
    cfg_state_s next_r;

    function automatic logic bank_ok(input logic [7:0] b);
        return b <= cfg_pkg::BANK_LAST;
    endfunction

    //--------------------------------------------------------------------------
    // address decode
    //--------------------------------------------------------------------------
    logic [15:0] index_addr;
    logic [15:0] data_addr;
    logic        sel_index;
    logic        sel_data;
    logic [7:0]  ptr;
    logic        is_bank_sel;
    logic        is_global;
    logic        is_act;
    logic [3:0]  glb_slot;
    logic [3:0]  bank_slot;
    logic [7:0]  window_rd;

    assign index_addr = r.high_base ? cfg_pkg::IO_INDEX_HI : cfg_pkg::IO_INDEX_LO; // see R1
    assign data_addr  = r.high_base ? cfg_pkg::IO_DATA_HI : cfg_pkg::IO_DATA_LO;   // see R1
    assign sel_index  = io.addr == index_addr;
    assign sel_data   = io.addr == data_addr;
    assign ptr        = r.config_pointer;
    assign is_bank_sel = ptr == cfg_pkg::IDX_BANK_SEL;                              // see R5
    assign is_global  = ptr >= cfg_pkg::IDX_GLB_LO && ptr <= cfg_pkg::IDX_GLB_HI;   // see R14
    assign is_act     = ptr == cfg_pkg::IDX_BANKED && bank_ok(r.bank_number);       // see R4, R17
    assign glb_slot   = ptr[3:0];
    assign bank_slot  = r.bank_number[3:0];

    // read mux of the data window
    always_comb begin
        window_rd = cfg_pkg::RESET_BYTE;                                            // see R7
        if (is_bank_sel) begin
            window_rd = r.bank_number;
        end else if (is_global) begin
            window_rd = r.global_reg[glb_slot];                                     // see R14
        end else if (is_act) begin
            window_rd = {7'h00, r.act[bank_slot]};                                  // see R13, R10
        end else if (ptr == cfg_pkg::IDX_DMA0 || ptr == cfg_pkg::IDX_DMA1) begin
            window_rd = cfg_pkg::DMA_NONE;                                          // see R8
        end
    end

    //--------------------------------------------------------------------------
    // next state
    //--------------------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.strap_sync = {r.strap_sync[0], port_address_strap};
        unique case (r.st)
            ST_FILL: begin
                next_r.st = ST_SETTLE;
            end
            ST_SETTLE: begin
                next_r.st = ST_CATCH;
            end
            ST_CATCH: begin
                next_r.high_base = r.strap_sync[1];                                 // see R1
                next_r.st        = ST_RUN;
            end
            ST_RUN: begin
                if (io.wr && sel_index) begin
                    next_r.config_pointer = io.wdata;                               // see R2
                end else if (io.wr && sel_data) begin                               // see R3, R15
                    if (is_bank_sel) begin
                        next_r.bank_number = io.wdata;                              // see R5
                    end else if (is_global) begin
                        next_r.global_reg[glb_slot] = io.wdata;
                    end else if (is_act) begin
                        next_r.act[bank_slot] = io.wdata[0];                        // see R13
                    end
                end
                if (io.rd && sel_index) begin
                    next_r.rdata = r.config_pointer;                                // see R2
                end else if (io.rd && sel_data) begin
                    next_r.rdata = window_rd;                                       // see R3
                end
            end
            default: begin
                next_r.st = ST_FILL;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r.st             <= ST_FILL;
            r.strap_sync     <= 2'b00;
            r.high_base      <= 1'b0;
            r.config_pointer <= cfg_pkg::RESET_BYTE;
            r.bank_number    <= cfg_pkg::RESET_BYTE;
            r.act            <= '0;
            r.global_reg     <= '0;
            r.rdata          <= cfg_pkg::RESET_BYTE;
        end else begin
            r <= next_r;
        end
    end

    //--------------------------------------------------------------------------
    // outputs
    //--------------------------------------------------------------------------
    assign io_hit        = (r.st == ST_RUN) && (sel_index || sel_data);             // see R9
    assign io_rdata      = r.rdata;
    assign device_enable = r.act;                                                   // see R16, R6

    //--------------------------------------------------------------------------
    // checks
    //--------------------------------------------------------------------------
    a_pointer_readback: assert property (@(posedge clk) disable iff (!reset_n) // see R2
        (r.st == ST_RUN && io.wr && sel_index) ##1 (io.rd && sel_index && !io.wr)
        |=> io_rdata == $past(io.wdata, 2))
        else $error("index read differs from last write");
    a_strap_base: assert property (@(posedge clk) disable iff (!reset_n) // see R1
        r.st == ST_CATCH |=> r.high_base == $past(port_address_strap, 3))
        else $error("strap not caught for port base");
    a_unimpl_read: assert property (@(posedge clk) disable iff (!reset_n) // see R7
        (r.st == ST_RUN && io.rd && sel_data && !is_bank_sel && !is_global && !is_act
         && ptr != 8'h74 && ptr != 8'h75) |=> io_rdata == 8'h00)
        else $error("unimplemented read not zero");
    a_dma_none: assert property (@(posedge clk) disable iff (!reset_n) // see R8
        (r.st == ST_RUN && io.rd && sel_data && (ptr == 8'h74 || ptr == 8'h75))
        |=> io_rdata == 8'h04)
        else $error("dma index not 04h");
    a_act_write: assert property (@(posedge clk) disable iff (!reset_n) // see R13
        (r.st == ST_RUN && io.wr && sel_data && ptr == 8'h30 && r.bank_number < 8'h0d)
        |=> device_enable[$past(bank_slot)] == $past(io.wdata[0]))
        else $error("activation bit not written");
    a_reserved_bank: assert property (@(posedge clk) disable iff (!reset_n) // see R17
        (r.st == ST_RUN && io.wr && sel_data && ptr == 8'h30 && r.bank_number > 8'h0c)
        |=> $stable(device_enable))
        else $error("reserved bank changed activation");
    a_bank_write: assert property (@(posedge clk) disable iff (!reset_n) // see R5
        (r.st == ST_RUN && io.wr && sel_data && ptr == 8'h07)
        |=> r.bank_number == $past(io.wdata))
        else $error("bank select not written");
    a_ready_soon: assert property (@(posedge clk) disable iff (!reset_n) // see R9
        $rose(reset_n) |-> ##[0:3] r.st == ST_RUN)
        else $error("not ready after reset");
    a_global_bank: assert property (@(posedge clk) disable iff (!reset_n) // see R14
        (r.st == ST_RUN && io.rd && sel_data && is_global)
        |=> io_rdata == $past(r.global_reg[glb_slot]))
        else $error("global read wrong");
    a_global_fixed: assert property (@(posedge clk) disable iff (!reset_n) // see R14
        (r.st == ST_RUN && io.wr && sel_data && ptr == 8'h07) |=> $stable(r.global_reg))
        else $error("bank select changed global registers");
    a_index_write: assert property (@(posedge clk) disable iff (!reset_n) // see R2
        (r.st == ST_RUN && io.wr && sel_index) |=> r.config_pointer == $past(io.wdata))
        else $error("index write not taken");
    a_read_hold: assert property (@(posedge clk) disable iff (!reset_n) // see R3
        !(r.st == ST_RUN && io.rd && (sel_index || sel_data)) |=> $stable(io_rdata))
        else $error("read data moved without a read");
    a_unimpl_write: assert property (@(posedge clk) disable iff (!reset_n) // see R7
        (r.st == ST_RUN && io.wr && sel_data && ptr != 8'h07 && ptr != 8'h30
         && !(ptr >= 8'h20 && ptr <= 8'h2f))
        |=> $stable(r.bank_number) && $stable(r.global_reg) && $stable(r.act))
        else $error("unimplemented write took effect");
endmodule : cfg_index_data
`default_nettype wire

// *** common/cfg_pkg.sv ***
// constants and carrier types for the configuration index/data access unit
package cfg_pkg;
    // i/o addresses of the port pair
    localparam logic [15:0] IO_INDEX_LO  = 16'h002e;
    localparam logic [15:0] IO_DATA_LO   = 16'h002f;
    localparam logic [15:0] IO_INDEX_HI  = 16'h004e;
    localparam logic [15:0] IO_DATA_HI   = 16'h004f;
    // configuration indices
    localparam logic [7:0]  IDX_BANK_SEL = 8'h07;
    localparam logic [7:0]  IDX_GLB_LO   = 8'h20;
    localparam logic [7:0]  IDX_GLB_HI   = 8'h2f;
    localparam logic [7:0]  IDX_BANKED   = 8'h30;
    localparam logic [7:0]  IDX_DMA0     = 8'h74;
    localparam logic [7:0]  IDX_DMA1     = 8'h75;
    // values
    localparam logic [7:0]  RESET_BYTE   = 8'h00;
    localparam logic [7:0]  DMA_NONE     = 8'h04;
    localparam logic [7:0]  ACT_MASK     = 8'h01;
    localparam int          NUM_BANKS    = 13;
    localparam logic [7:0]  BANK_LAST    = 8'h0c;
    localparam int          NUM_GLOBAL   = 16;

    // bank numbers of the logical devices
    typedef enum logic [3:0] {
        BANK_FLOPPY    = 4'h0,
        BANK_PRINTER   = 4'h1,
        BANK_SERIAL2   = 4'h2,
        BANK_SERIAL1   = 4'h3,
        BANK_WAKEUP    = 4'h4,
        BANK_MOUSE     = 4'h5,
        BANK_KEYBOARD  = 4'h6,
        BANK_GPIO      = 4'h7,
        BANK_TWO_WIRE  = 4'h8,
        BANK_FAN       = 4'h9,
        BANK_WATCH     = 4'ha,
        BANK_JOYSTICK  = 4'hb,
        BANK_MUSIC     = 4'hc
    } cfg_bank_e;

    // internal 8-bit i/o cycle as bridged from the host bus
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } cfg_io_s;
endpackage : cfg_pkg

// *** dv/cfg_host_model.sv ***
// host-side model issuing 8-bit i/o cycles to the configuration unit
`timescale 1ns/100ps
`default_nettype none
module cfg_host_model (
    // clock
    input  wire logic             clk,
    // i/o cycle to the unit
    output var cfg_pkg::cfg_io_s  io,
    input  wire logic             io_hit,
    input  wire logic [7:0]       io_rdata
);
    initial io = '0;
    // one-cycle write pulse, plain write only
    task automatic io_write(input logic [15:0] a, input logic [7:0] d, output logic hit);
        @(posedge clk) #1;
        io = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        #1 hit = io_hit;
        @(posedge clk) #1;
        io = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask
    // one-cycle read pulse, data taken after the accepting edge
    task automatic io_read(input logic [15:0] a, output logic [7:0] d, output logic hit);
        @(posedge clk) #1;
        io = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: io.wdata};
        #1 hit = io_hit;
        @(posedge clk) #1;
        d = io_rdata;
        io = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~io.wdata};
    endtask
    // write then read of one port on back-to-back edges
    task automatic io_write_read(input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk) #1;
        io = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge clk) #1;
        io = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: d};
        @(posedge clk) #1;
        q = io_rdata;
        io = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule // cfg_host_model
`default_nettype wire

// *** dv/testbench.sv ***
// self-checking bench for the configuration index/data unit
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic                 clk = 1'b0;
    logic                 reset_n = 1'b0;
    logic                 strap = 1'b0;
    cfg_pkg::cfg_io_s     io;
    logic                 io_hit;
    logic [7:0]           io_rdata;
    logic [12:0]          en;
    logic [15:0]          base = cfg_pkg::IO_INDEX_LO;
    logic [7:0]           v;
    logic                 h;
    int                   err_count = 0;
    int                   checks_done = 0;
    always #20 clk = ~clk;
    cfg_index_data i_dut (.clk(clk), .reset_n(reset_n), .port_address_strap(strap),
        .io(io), .io_hit(io_hit), .io_rdata(io_rdata), .device_enable(en));
    cfg_host_model i_host (.clk(clk), .io(io), .io_hit(io_hit), .io_rdata(io_rdata));
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic do_reset(input logic s);
        reset_n = 1'b0;
        strap = s;
        repeat (20) @(posedge clk);
        #1 reset_n = 1'b1;
        base = s ? cfg_pkg::IO_INDEX_HI : cfg_pkg::IO_INDEX_LO;
        // strap synchroniser and catch take the first edges after release
        repeat (2) @(posedge clk);
    endtask
    task automatic put(input logic [7:0] idx, input logic [7:0] d);
        i_host.io_write(base, idx, h);
        i_host.io_write(base + 16'h0001, d, h);
    endtask
    task automatic get(input logic [7:0] idx, input logic [7:0] exp, input string nm);
        i_host.io_write(base, idx, h);
        i_host.io_read(base + 16'h0001, v, h);
        check(nm, {8'h00, v}, {8'h00, exp});
    endtask
    initial begin
        #(40 * 5000);
        err_count++;
        give_verdict();
    end
    initial begin
        do_reset(1'b0);
        i_host.io_read(base, v, h);
        check("index_reset", {8'h00, v}, 16'h0000);
        check("hit_index", {15'h0000, h}, 16'h0001);
        put(cfg_pkg::IDX_BANK_SEL, 8'h03);
        get(cfg_pkg::IDX_BANK_SEL, 8'h03, "bank_sel");
        get(cfg_pkg::IDX_BANKED, 8'h00, "act_before");
        put(cfg_pkg::IDX_BANKED, 8'h01);
        check("enable_b3", {3'h0, en}, 16'h0008);
        get(cfg_pkg::IDX_BANKED, 8'h01, "act_after");
        i_host.io_read(base, v, h);
        check("index_back", {8'h00, v}, 16'h0030);
        put(8'h25, 8'ha5);
        put(cfg_pkg::IDX_BANK_SEL, 8'h05);
        get(8'h25, 8'ha5, "global");
        put(8'h40, 8'h55);
        get(8'h40, 8'h00, "unimpl");
        get(cfg_pkg::IDX_DMA0, cfg_pkg::DMA_NONE, "dma0");
        get(cfg_pkg::IDX_DMA1, cfg_pkg::DMA_NONE, "dma1");
        put(cfg_pkg::IDX_BANK_SEL, 8'h0d);
        put(cfg_pkg::IDX_BANKED, 8'h01);
        get(cfg_pkg::IDX_BANKED, 8'h00, "rsv_act");
        get(cfg_pkg::IDX_DMA0, cfg_pkg::DMA_NONE, "rsv_dma");
        check("enable_rsv", {3'h0, en}, 16'h0008);
        for (int b = 0; b < cfg_pkg::NUM_BANKS; b++) begin
            put(cfg_pkg::IDX_BANK_SEL, 8'(b));
            put(cfg_pkg::IDX_BANKED, 8'h01);
            check("enable_each", {3'h0, en}, 16'h0008 | ((16'h0002 << b) - 16'h0001));
        end
        i_host.io_write(cfg_pkg::IO_INDEX_HI, 8'h11, h);
        check("hit_foreign", {15'h0000, h}, 16'h0000);
        i_host.io_read(base, v, h);
        check("index_kept", {8'h00, v}, 16'h0030);
        i_host.io_write_read(base, 8'h5a, v);
        check("index_b2b", {8'h00, v}, 16'h005a);
        do_reset(1'b1);
        check("enable_rst", {3'h0, en}, 16'h0000);
        i_host.io_write(cfg_pkg::IO_INDEX_LO, 8'h07, h);
        check("hit_low_off", {15'h0000, h}, 16'h0000);
        get(cfg_pkg::IDX_BANK_SEL, 8'h00, "bank_rst");
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
